// [rtl/wswc_pkg.sv]
// package for the watchdog, sleep and wake-up control block
// assumes a 10 MHz system clock and an AXI4-Lite register bus
package wswc_pkg;

	// timing
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned WDT_BASE_MS   = 18;
	localparam int unsigned WDT_BASE_CYC  =
		WDT_BASE_MS * 1000000 / CLK_PERIOD_NS;
	localparam int unsigned WDT_BASE_W    = 24;
	localparam int unsigned PRESCALE_W    = 8;
	localparam int unsigned PS_SEL_W      = 3;
	localparam logic [1:0]  FUSE_SETTLE   = 2'h3;

	// core facing widths
	localparam int unsigned PC_W  = 13;
	localparam int unsigned IRQ_N = 3;

	// register indices; byte address is four times the low 14 bits of the index
	localparam int unsigned AXI_AW      = 16;
	localparam logic [15:0] OPTION_IDX  = 16'h0081;
	localparam logic [15:0] CONFIG_IDX  = 16'h2007;
	localparam logic [15:0] STATUS_IDX  = 16'h0003;
	localparam logic [15:0] OPTION_ADDR = {OPTION_IDX[13:0], 2'h0};
	localparam logic [15:0] CONFIG_ADDR = {CONFIG_IDX[13:0], 2'h0};
	localparam logic [15:0] STATUS_ADDR = {STATUS_IDX[13:0], 2'h0};

	// fields and reset values
	localparam logic [7:0]  OPTION_RESET = 8'hFF;
	localparam int unsigned OPT_PSA_BIT  = 3;
	localparam int unsigned OPT_PS_LSB   = 0;
	localparam int unsigned CFG_WATCHDOG_ENABLE_FUSE_BIT = 3;
	localparam int unsigned STAT_TO_BIT  = 4;
	localparam int unsigned STAT_PD_BIT  = 3;
	localparam logic [7:0]  CFG_RESET    = 8'h00;

	// bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic               clear_watchdog_instruction;
		logic               sleep;
		logic               global_interrupt_enable;
		logic [IRQ_N-1:0]   intEn;
		logic [IRQ_N-1:0]   intFlag;
		logic [PC_W-1:0]    pc;
	} wswc_core_cmd_t;

	typedef enum {ST_RUN, ST_SLEEP} wswc_state_t;

endpackage

// [rtl/wswc_sync.sv]
// two flip-flop synchroniser bank for pin inputs
// assumes inputs are asynchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
module wswc_sync #(
	parameter int unsigned    W         = 1,
	parameter logic [W-1:0]   RESET_VAL = '0
) (
	input  wire logic         sys_clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] din,
	output var  logic [W-1:0] dout
);

	logic [W-1:0] stage1_q;

	// first stage feeds only the second stage
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				stage1_q[i] <= RESET_VAL[i];
				dout[i]     <= RESET_VAL[i];
			end else begin
				stage1_q[i] <= din[i];
				dout[i]     <= stage1_q[i];
			end
		end
	end

endmodule // wswc_sync
`default_nettype wire

// [rtl/wswc_wdt_counter.sv]
// watchdog base counter plus optional power-of-two prescaler
// assumes enable comes from a fuse and clear from the control logic
`timescale 1ns/1ps
`default_nettype none
module wswc_wdt_counter
	import wswc_pkg::*;
#(
	parameter int unsigned BASE_CYCLES = WDT_BASE_CYC
) (
	input  wire logic                sys_clk,
	input  wire logic                rst,
	input  wire logic                enable,
	input  wire logic                clear,
	input  wire logic                prescaleOn,
	input  wire logic [PS_SEL_W-1:0] prescaleSel,
	output var  logic                timeout_q
);

	logic [WDT_BASE_W-1:0] baseCnt_q;
	logic [PRESCALE_W-1:0] preCnt_q;
	logic                  baseWrap;
	logic [PRESCALE_W-1:0] preLimit;
	logic                  preWrap;

	assign baseWrap = baseCnt_q == WDT_BASE_W'(BASE_CYCLES - 1);
	assign preLimit = (PRESCALE_W'(1) << prescaleSel) - PRESCALE_W'(1);
	assign preWrap  = !prescaleOn || preCnt_q == preLimit;

	// free-running tick, independent of sleep or core clock gating
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			baseCnt_q <= '0;
		end else if (clear || !enable || baseWrap) begin
			baseCnt_q <= '0;
		end else begin
			baseCnt_q <= baseCnt_q + WDT_BASE_W'(1);
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			preCnt_q <= '0;
		end else if (clear || !enable || !prescaleOn) begin
			preCnt_q <= '0;
		end else if (baseWrap) begin
			preCnt_q <= preWrap ? '0 : preCnt_q + PRESCALE_W'(1);
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			timeout_q <= 1'b0;
		end else begin
			timeout_q <= enable && !clear && baseWrap && preWrap;
		end
	end

endmodule // wswc_wdt_counter
`default_nettype wire

// [rtl/wswc_ctrl.sv]
// watchdog, sleep and wake-up control with AXI4-Lite registers
// assumes the core drives its command struct on sys_clk; pins are
// asynchronous and synchronised here
`timescale 1ns/1ps
`default_nettype none

// Function
// - watchdog ticks from its own free source
// - timeout while awake resets the device
// - timeout while asleep wakes the device
// - cleared enable fuse disables watchdog permanently
// - base timeout period is nominally 18 ms
// - option register assigns prescaler up to 1:128
// - clear or sleep resets count and prescaler
// - timeout clears the time-out status flag
// - sleep clears dog and power-down flag, sets time-out flag, stops oscillator, holds pins
// - watchdog reset never drives master clear pin
// - wake on reset, watchdog or interrupt
// - power-down flag set at power-up, cleared by sleep
// - sleep prefetches instruction at pc plus one
// - enabled source wakes regardless of global enable
// - after interrupt wake, vector only if global enabled
// - pending enabled interrupt makes sleep wake immediately
// - any wake-up clears the watchdog count
module wswc_ctrl
	import wswc_pkg::*;
#(
	parameter int unsigned BASE_CYCLES = WDT_BASE_CYC
) (
	input  wire logic              sys_clk,
	input  wire logic              rst,
	input  wire logic              masterClearN,
	input  wire logic [7:0]        cfgFuses,
	input  wire wswc_core_cmd_t    cmd,
	output var  logic              deviceReset_q,
	output var  logic              wakeUp_q,
	output var  logic              vectorReq_q,
	output var  logic              oscDriverOn_q,
	output var  logic              ioHold_q,
	output var  logic [PC_W-1:0]   prefetchAddr_q,
	output var  logic              timeoutFlagN_q,
	output var  logic              powerdownFlagN_q,
	input  wire logic [AXI_AW-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output var  logic              s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output var  logic              s_axi_wready,
	output var  logic [1:0]        s_axi_bresp,
	output var  logic              s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [AXI_AW-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output var  logic              s_axi_arready,
	output var  logic [31:0]       s_axi_rdata,
	output var  logic [1:0]        s_axi_rresp,
	output var  logic              s_axi_rvalid,
	input  wire logic              s_axi_rready
);

	wswc_state_t       state_q;
	logic              mclrSyncN;
	logic [7:0]        cfgSync;
	logic [7:0]        cfg_q;
	logic              cfgLoaded_q;
	logic [1:0]        settleCnt_q;
	logic [7:0]        option_q;
	logic              wdtOn;
	logic              wdtTimeout;
	logic              wdtClear;
	logic              mclrActive;
	logic              irqPending;
	logic              sleepAccept;
	logic              wakeNow;
	logic              irqWake;
	logic              coreGie;
	logic              awHave_q;
	logic              wHave_q;
	logic [AXI_AW-1:0] awAddr_q;
	logic [31:0]       wData_q;
	logic [3:0]        wStrb_q;
	logic              doWrite;
	logic [31:0]       rdNext;
	logic [1:0]        rdResp;

	wswc_sync #(
		.W         (9),
		.RESET_VAL (9'h100)
	) u_sync (
		.sys_clk (sys_clk),
		.rst     (rst),
		.din     ({masterClearN, cfgFuses}),
		.dout    ({mclrSyncN, cfgSync})
	);

	wswc_wdt_counter #(
		.BASE_CYCLES (BASE_CYCLES)
	) u_wdt (
		.sys_clk     (sys_clk),
		.rst         (rst),
		.enable      (wdtOn),
		.clear       (wdtClear),
		.prescaleOn  (option_q[OPT_PSA_BIT]),
		.prescaleSel (option_q[OPT_PS_LSB +: PS_SEL_W]),
		.timeout_q   (wdtTimeout)
	);

	// fuses captured once after the synchroniser has settled
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			settleCnt_q <= 2'h0;
			cfgLoaded_q <= 1'b0;
			cfg_q       <= CFG_RESET;
		end else if (!cfgLoaded_q) begin
			if (settleCnt_q == FUSE_SETTLE) begin
				cfgLoaded_q <= 1'b1;
				cfg_q       <= cfgSync;
			end else begin
				settleCnt_q <= settleCnt_q + 2'h1;
			end
		end
	end

	// no software path writes cfg_q, so a cleared fuse cannot be undone
	assign wdtOn      = cfgLoaded_q && cfg_q[CFG_WATCHDOG_ENABLE_FUSE_BIT];
	assign mclrActive = !mclrSyncN;
	assign coreGie    = cmd.global_interrupt_enable;
	assign irqPending = |(cmd.intEn & cmd.intFlag);
	assign sleepAccept = cmd.sleep && state_q == ST_RUN && !mclrActive
		&& !wdtTimeout;
	assign wakeNow    = state_q == ST_SLEEP && !mclrActive
		&& (wdtTimeout || irqPending);
	assign irqWake    = wakeNow && !wdtTimeout;
	assign wdtClear   = cmd.clear_watchdog_instruction || sleepAccept || wakeNow
		|| mclrActive;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_RUN;
		end else if (mclrActive) begin
			state_q <= ST_RUN;
		end else begin
			unique case (state_q)
				ST_RUN: begin
					if (sleepAccept) begin
						state_q <= ST_SLEEP;
					end
				end
				ST_SLEEP: begin
					if (wakeNow) begin
						state_q <= ST_RUN;
					end
				end
			endcase
		end
	end

	// internal reset only; the master clear pin is an input here
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			deviceReset_q <= 1'b0;
		end else begin
			deviceReset_q <= mclrActive
				|| (wdtTimeout && state_q == ST_RUN);
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wakeUp_q    <= 1'b0;
			vectorReq_q <= 1'b0;
		end else begin
			wakeUp_q    <= wakeNow;
			vectorReq_q <= irqWake && coreGie;
		end
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			oscDriverOn_q  <= 1'b1;
			ioHold_q       <= 1'b0;
			prefetchAddr_q <= '0;
		end else if (sleepAccept) begin
			oscDriverOn_q  <= 1'b0;
			ioHold_q       <= 1'b1;
			prefetchAddr_q <= cmd.pc + PC_W'(1);
		end else if (wakeNow || mclrActive) begin
			oscDriverOn_q  <= 1'b1;
			ioHold_q       <= 1'b0;
		end
	end

	// a timeout in the same cycle as a clear wins
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			timeoutFlagN_q <= 1'b1;
		end else if (wdtTimeout) begin
			timeoutFlagN_q <= 1'b0;
		end else if (cmd.clear_watchdog_instruction || sleepAccept) begin
			timeoutFlagN_q <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			powerdownFlagN_q <= 1'b1;
		end else if (sleepAccept) begin
			powerdownFlagN_q <= 1'b0;
		end else if (cmd.clear_watchdog_instruction) begin
			powerdownFlagN_q <= 1'b1;
		end
	end

	// write channel: address and data taken in either order
	assign doWrite = awHave_q && wHave_q && !s_axi_bvalid;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_axi_awready <= 1'b1;
			awHave_q      <= 1'b0;
			awAddr_q      <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			s_axi_awready <= 1'b0;
			awHave_q      <= 1'b1;
			awAddr_q      <= s_axi_awaddr;
		end else if (doWrite) begin
			awHave_q      <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_axi_wready <= 1'b1;
			wHave_q      <= 1'b0;
			wData_q      <= '0;
			wStrb_q      <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			s_axi_wready <= 1'b0;
			wHave_q      <= 1'b1;
			wData_q      <= s_axi_wdata;
			wStrb_q      <= s_axi_wstrb;
		end else if (doWrite) begin
			wHave_q      <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_wready <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (doWrite) begin
			s_axi_bvalid <= 1'b1;
			unique case (awAddr_q)
				OPTION_ADDR, CONFIG_ADDR, STATUS_ADDR: begin
					s_axi_bresp <= RESP_OKAY;
				end
				default: begin
					s_axi_bresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// only the option register is writable; read-only writes are dropped
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			option_q <= OPTION_RESET;
		end else if (doWrite && awAddr_q == OPTION_ADDR && wStrb_q[0]) begin
			option_q <= wData_q[7:0];
		end
	end

	always_comb begin
		rdNext = 32'h0000_0000;
		rdResp = RESP_OKAY;
		unique case (s_axi_araddr)
			OPTION_ADDR: begin
				rdNext[7:0] = option_q;
			end
			CONFIG_ADDR: begin
				rdNext[7:0] = cfg_q;
			end
			STATUS_ADDR: begin
				rdNext[STAT_TO_BIT] = timeoutFlagN_q;
				rdNext[STAT_PD_BIT] = powerdownFlagN_q;
			end
			default: begin
				rdResp = RESP_SLVERR;
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rdNext;
			s_axi_rresp   <= rdResp;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	AST_TIMEOUT_RESET: assert property (
		wdtTimeout && state_q == ST_RUN |=> deviceReset_q && !wakeUp_q)
		else $error("awake timeout did not reset the device");
	AST_TIMEOUT_WAKE: assert property (
		wdtTimeout && state_q == ST_SLEEP && !mclrActive
		|=> wakeUp_q && !deviceReset_q && state_q == ST_RUN)
		else $error("sleeping timeout did not wake the device");
	AST_FUSE_OFF: assert property (
		!wdtOn |=> !wdtTimeout)
		else $error("timeout with watchdog fuse cleared");
	AST_CLEAR_HOLDS: assert property (
		wdtClear |=> !wdtTimeout [*2])
		else $error("timeout right after a watchdog clear");
	AST_TO_FLAG: assert property (
		wdtTimeout |=> !timeoutFlagN_q)
		else $error("time-out flag not cleared by timeout");
	AST_SLEEP_ENTRY: assert property (
		sleepAccept |=> !powerdownFlagN_q && timeoutFlagN_q
		&& !oscDriverOn_q && ioHold_q)
		else $error("sleep entry effects missing");
	AST_PD_KEEP: assert property (
		!sleepAccept && !cmd.clear_watchdog_instruction |=> $stable(powerdownFlagN_q))
		else $error("power-down flag changed without cause");
	AST_PREFETCH: assert property (
		sleepAccept |=> prefetchAddr_q == $past(cmd.pc) + PC_W'(1))
		else $error("prefetch address is not pc plus one");
	AST_IRQ_WAKE: assert property (
		state_q == ST_SLEEP && irqPending && !mclrActive |=> wakeUp_q)
		else $error("enabled interrupt did not wake the device");
	AST_VECTOR: assert property (
		irqWake |=> vectorReq_q == $past(coreGie))
		else $error("vector request does not follow global enable");
	AST_IMM_WAKE: assert property (
		sleepAccept && irqPending ##1 irqPending && !mclrActive
		|=> wakeUp_q && !ioHold_q)
		else $error("pending interrupt did not wake at once");
	AST_WAKE_CLEAR: assert property (
		wakeNow |=> !wdtTimeout ##1 !wdtTimeout)
		else $error("watchdog not cleared on wake-up");

	COV_WDT_RESET: cover property (wdtTimeout && state_q == ST_RUN);
	COV_WDT_WAKE: cover property (wdtTimeout && state_q == ST_SLEEP);
	COV_IRQ_WAKE: cover property (irqWake ##1 vectorReq_q);
	COV_IMM_WAKE: cover property (sleepAccept && irqPending ##2 wakeUp_q);

endmodule // wswc_ctrl
`default_nettype wire

// [verification/wswc_core_model.sv]
// processor core model: issues clear and sleep instructions
// assumes it shares sys_clk with the block and drives on rising edges
`timescale 1ns/1ps
`default_nettype none
module wswc_core_model
	import wswc_pkg::*;
(
	input  wire logic           sys_clk,
	input  wire logic           wakeUp_q,
	output var  wswc_core_cmd_t cmd
);
	int nopCount = 0;

	initial cmd = '0;

	// one-cycle instruction pulse, released an edge later
	task automatic pulse(input logic isSleep, input logic [PC_W-1:0] pc);
		@(posedge sys_clk);
		cmd.sleep  <= isSleep;
		cmd.clear_watchdog_instruction <= !isSleep;
		cmd.pc     <= pc;
		@(posedge sys_clk);
		cmd.sleep  <= 1'b0;
		cmd.clear_watchdog_instruction <= 1'b0;
	endtask

	task automatic irq(input logic [IRQ_N-1:0] en,
		input logic [IRQ_N-1:0] fl, input logic g);
		@(posedge sys_clk);
		cmd.intEn   <= en;
		cmd.intFlag <= fl;
		cmd.global_interrupt_enable     <= g;
	endtask

	// word after sleep is a no-op, so a wake never repeats real work
	always @(posedge sys_clk) begin
		if (wakeUp_q === 1'b1) nopCount <= nopCount + 1;
	end
endmodule // wswc_core_model
`default_nettype wire

// [verification/wswc_ctrl_tb.sv]
// self-checking bench for the watchdog, sleep and wake-up control
// assumes the core model and the block share one 10 MHz clock
`timescale 1ns/1ps
`default_nettype none
module wswc_ctrl_tb
	import wswc_pkg::*;
;
	localparam int BASE = 8;
	logic              sys_clk = 1'b0;
	logic              rst = 1'b1;
	logic              masterClearN = 1'b1;
	logic [7:0]        cfgFuses = 8'h08;
	wswc_core_cmd_t    cmd;
	logic              deviceReset_q, wakeUp_q, vectorReq_q;
	logic              oscDriverOn_q, ioHold_q;
	logic              timeoutFlagN_q, powerdownFlagN_q;
	logic [PC_W-1:0]   prefetchAddr_q;
	logic [AXI_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0]       s_axi_wdata = '0, s_axi_rdata;
	logic [3:0]        s_axi_wstrb = 4'hF;
	logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic              s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic              s_axi_rready = 1'b0;
	logic              s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic              s_axi_arready, s_axi_rvalid;
	logic [1:0]        s_axi_bresp, s_axi_rresp;
	int                err_total = 0, total_checks = 0;
	logic [31:0]       seed = 32'hE1741550;
	logic              evRst, evWake, evVec;

	always #50 sys_clk = ~sys_clk;

	wswc_ctrl #(.BASE_CYCLES(BASE)) uut (.sys_clk, .rst, .masterClearN,
		.cfgFuses, .cmd, .deviceReset_q, .wakeUp_q, .vectorReq_q,
		.oscDriverOn_q, .ioHold_q, .prefetchAddr_q, .timeoutFlagN_q,
		.powerdownFlagN_q, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	wswc_core_model core (.sys_clk, .wakeUp_q, .cmd);

	function logic [31:0] nextRand();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function int expPeriod(input logic [7:0] opt);
		return opt[OPT_PSA_BIT] ? BASE << opt[2:0] : BASE;
	endfunction

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] s);
		total_checks++;
		if (s !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic chkIn(input string nm, input int lo, input int hi,
		input int s);
		total_checks++;
		if (s < lo || s > hi) begin
			err_total++;
			$display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, s);
		end
	endtask

	task automatic wrChk(input logic [15:0] a, input logic [31:0] d,
		input logic [1:0] er);
		bit aw, w;
		int n;
		aw = 0;
		w = 0;
		n = 0;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
			if (!aw && s_axi_awready === 1'b1) begin
				aw = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w && s_axi_wready === 1'b1) begin
				w = 1;
				s_axi_wvalid <= 1'b0;
			end
		end while (!(aw && w) && n < 50);
		while (s_axi_bvalid !== 1'b1 && n < 50) begin
			@(posedge sys_clk);
			n++;
		end
		chk("bvalid", 1'b1, s_axi_bvalid);
		chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
		s_axi_bready <= 1'b0;
	endtask

	task automatic rdChk(input logic [15:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		int n;
		n = 0;
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (s_axi_arready !== 1'b1 && n < 50);
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1 && n < 50) begin
			@(posedge sys_clk);
			n++;
		end
		chk("rvalid", 1'b1, s_axi_rvalid);
		chk("rdata", ed, s_axi_rdata);
		chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
		s_axi_rready <= 1'b0;
	endtask

	// counts edges until a reset or wake pulse, or the limit
	task automatic waitEvt(input int lim, output int n);
		n = 0;
		evRst = 1'b0;
		evWake = 1'b0;
		evVec = 1'b0;
		while (n < lim && !evRst && !evWake) begin
			@(posedge sys_clk);
			n++;
			evRst = deviceReset_q === 1'b1;
			evWake = wakeUp_q === 1'b1;
			evVec = vectorReq_q === 1'b1;
		end
	endtask

	task automatic sleepNow();
		logic [31:0]     v;
		logic [PC_W-1:0] nx;
		v = nextRand();
		nx = v[PC_W-1:0] + 1'b1;
		core.pulse(1'b1, v[PC_W-1:0]);
		@(posedge sys_clk);
		chk("osc", 1'b0, oscDriverOn_q);
		chk("ioHold", 1'b1, ioHold_q);
		chk("pdFlag", 1'b0, powerdownFlagN_q);
		chk("toFlag", 1'b1, timeoutFlagN_q);
		chk("prefetch", nx, prefetchAddr_q);
	endtask

	task automatic final_report();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		#3000000;
		err_total++;
		final_report();
	end

	initial begin
		int          n, p;
		logic [31:0] v;
		logic        g;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		rdChk(OPTION_ADDR, 32'hFF, RESP_OKAY);
		rdChk(CONFIG_ADDR, 32'h08, RESP_OKAY);
		rdChk(STATUS_ADDR, 32'h18, RESP_OKAY);
		wrChk(CONFIG_ADDR, 32'hFF, RESP_OKAY);
		rdChk(CONFIG_ADDR, 32'h08, RESP_OKAY);
		rdChk(16'h0100, 32'h0, RESP_SLVERR);
		wrChk(16'h0100, 32'h1, RESP_SLVERR);
		// keep a long period while the bus is exercised
		v = (nextRand() & 32'hFF) | 32'h0F;
		wrChk(OPTION_ADDR, v, RESP_OKAY);
		rdChk(OPTION_ADDR, v, RESP_OKAY);
		// low byte strobe off: the option register must keep its value
		s_axi_wstrb <= 4'hE;
		wrChk(OPTION_ADDR, 32'h0, RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		rdChk(OPTION_ADDR, v, RESP_OKAY);
		// longest first, so no expiry lands inside a write
		for (int k = 0; k < 9; k++) begin
			v = (k == 8) ? 32'h0 : 32'h8 | 32'(7 - k);
			wrChk(OPTION_ADDR, v, RESP_OKAY);
			core.pulse(1'b0, '0);
			waitEvt(3000, n);
			p = expPeriod(v[7:0]);
			chkIn("period", p, p + 3, n);
			chk("reset", 1'b1, evRst);
			chk("toFlag", 1'b0, timeoutFlagN_q);
		end
		rdChk(STATUS_ADDR, 32'h08, RESP_OKAY);
		wrChk(OPTION_ADDR, 32'h0, RESP_OKAY);
		repeat (10) begin
			core.pulse(1'b0, '0);
			waitEvt(4, n);
			chk("noReset", 1'b0, evRst);
		end
		sleepNow();
		waitEvt(100, n);
		chkIn("wakeTime", BASE - 1, BASE + 2, n);
		chk("wake", 1'b1, evWake);
		chk("noRst", 1'b0, evRst);
		chk("vector", 1'b0, evVec);
		chk("toFlag", 1'b0, timeoutFlagN_q);
		chk("oscOn", 1'b1, oscDriverOn_q);
		chk("ioRel", 1'b0, ioHold_q);
		waitEvt(100, n);
		chkIn("afterWake", BASE, BASE + 3, n);
		chk("awakeRst", 1'b1, evRst);
		wrChk(OPTION_ADDR, 32'h0F, RESP_OKAY);
		for (int i = 0; i < IRQ_N; i++) begin
			v = nextRand();
			g = v[0];
			sleepNow();
			core.irq('0, IRQ_N'(1 << i), 1'b1);
			waitEvt(6, n);
			chk("noWake", 1'b0, evWake);
			core.irq(IRQ_N'(1 << i), IRQ_N'(1 << i), g);
			waitEvt(4, n);
			chk("irqWake", 1'b1, evWake);
			chk("vector", g, evVec);
			core.irq('0, '0, 1'b0);
		end
		core.irq(3'h4, 3'h4, 1'b0);
		sleepNow();
		waitEvt(4, n);
		chkIn("pendWake", 1, 2, n);
		chk("pendVec", 1'b0, evVec);
		core.irq('0, '0, 1'b0);
		sleepNow();
		masterClearN <= 1'b0;
		waitEvt(6, n);
		chk("mclrRst", 1'b1, evRst);
		masterClearN <= 1'b1;
		repeat (4) @(posedge sys_clk);
		chk("mclrRun", 1'b1, oscDriverOn_q);
		chk("pdKept", 1'b0, powerdownFlagN_q);
		cfgFuses <= 8'h00;
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		rdChk(STATUS_ADDR, 32'h18, RESP_OKAY);
		wrChk(OPTION_ADDR, 32'h0, RESP_OKAY);
		waitEvt(200, n);
		chk("fuseOff", 1'b0, evRst);
		// one watchdog, three interrupt and one pending-interrupt wake
		chk("wakes", 32'h5, core.nopCount);
		final_report();
	end
endmodule // wswc_ctrl_tb
`default_nettype wire
